/* File: src/cell_balance_pkg.sv */
// Purpose: shared constants and types for the cell balance drive control
// Assumes: 20 MHz system clock
// Notes: one enable bit per balance output
package cell_balance_pkg;
    localparam int NUM_CELLS = 14;
    localparam int SETUP_W = 16;
    localparam int INTERNAL_SEL_BIT = 8;
    localparam logic INTERNAL_SEL_RESET = 1'b0;
    localparam logic [NUM_CELLS-1:0] DRIVE_RESET = 14'h0000;
    localparam int CLK_HZ = 20000000;
    localparam int PAUSE_LEAD_MS = 10;
    localparam int PAUSE_LEAD_CYC = (CLK_HZ / 1000) * PAUSE_LEAD_MS;
    localparam int ADC_W = 14;
    localparam logic [ADC_W-1:0] ADC_FULL_SCALE = 14'h3fff;

    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_TIMED,
        MODE_AUTO
    } balance_mode_e;

    typedef struct packed {
        logic suspend;
        logic resume;
        logic scan_request;
        logic scan_done;
    } balance_cmd_s;
endpackage

/* File: src/cell_balance_drive_control.sv */
// Purpose: gate the per-cell balance drive outputs by mode, host commands and scans
// Assumes: commands are one-cycle pulses synchronous to sys_clk_i
// Notes: scan_start_o pulses once the pre-scan lead time has elapsed when scan-pause applies, else one edge after the request
// Operation
// - bit 8 clear selects external FET drive
// - reset leaves external FET drive selected
// - bit 8 set routes through internal switches
// - gate current source on only when balancing
// - over-range conversion saturates at full scale
// - suspend forces off; resume restores prior state
// - scan-pause: drive off 10ms before continuous scans
// - drive restored automatically after scan ends
// - auto mode pauses likewise with scan-pause
// - manual mode: each output follows its bit
`timescale 1ns/100ps
`default_nettype none
module cell_balance_drive_control #(
    parameter int PAUSE_CYC = cell_balance_pkg::PAUSE_LEAD_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic setup_we_i,
    input wire logic [cell_balance_pkg::SETUP_W-1:0] setup_data_i,
    input wire logic [cell_balance_pkg::NUM_CELLS-1:0] manual_bits_i,
    input wire logic [cell_balance_pkg::NUM_CELLS-1:0] seq_bits_i,
    input wire cell_balance_pkg::balance_mode_e mode_i,
    input wire logic balance_run_i,
    input wire logic scan_pause_enable_i,
    input wire logic scan_continuous_i,
    input wire cell_balance_pkg::balance_cmd_s cmd_i,
    input wire logic [cell_balance_pkg::ADC_W:0] adc_raw_i,
    output logic internal_balance_select_o,
    output logic [cell_balance_pkg::NUM_CELLS-1:0] balance_drive_output_o,
    output logic [cell_balance_pkg::NUM_CELLS-1:0] ext_source_on_o,
    output logic [cell_balance_pkg::NUM_CELLS-1:0] int_switch_on_o,
    output logic [cell_balance_pkg::ADC_W-1:0] adc_result_o,
    output logic scan_start_o,
    output logic suspended_o
);
    import cell_balance_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_LEAD, S_SCAN} scan_st_e;

    ////////////////////////////////////////////////////////////////////////
    logic internal_sel;
    logic suspended;
    scan_st_e scan_st;
    logic [31:0] lead_cnt;

    ////////////////////////////////////////////////////////////////////////
    // manual mode takes the host bits, the sequencers share one pattern input
    function automatic logic [NUM_CELLS-1:0] select_pattern(
        input balance_mode_e mode,
        input logic [NUM_CELLS-1:0] manual,
        input logic [NUM_CELLS-1:0] seq
    );
        select_pattern = (mode == MODE_MANUAL) ? manual : seq;
    endfunction

    wire [NUM_CELLS-1:0] commanded = select_pattern(mode_i, manual_bits_i, seq_bits_i);
    wire active = balance_run_i && (commanded != '0);
    // auto mode uses the same pause path; any mode counts once continuous scan runs
    wire pause_applies = scan_pause_enable_i && scan_continuous_i && active;
    wire scan_paused = (scan_st != S_IDLE);
    // suspend only masks, so the commanded pattern is kept and returns on resume
    wire [NUM_CELLS-1:0] next_drive = (balance_run_i && !suspended && !scan_paused)
        ? commanded : '0;
    // full count: drive is only off two edges after the request
    wire lead_done = (lead_cnt >= 32'(PAUSE_CYC));
    wire adc_over = adc_raw_i[ADC_W];

    // per-cell steering; the two enables of a cell can never be on together
    wire [NUM_CELLS-1:0] ext_next;
    wire [NUM_CELLS-1:0] int_next;
    for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
        assign ext_next[c] = !internal_sel && next_drive[c];
        assign int_next[c] = internal_sel && next_drive[c];
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            internal_sel <= INTERNAL_SEL_RESET;
        end else if (setup_we_i) begin
            internal_sel <= setup_data_i[INTERNAL_SEL_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            suspended <= 1'b0;
        // suspend tested first, so it wins over a resume in the same cycle
        end else if (cmd_i.suspend) begin
            suspended <= 1'b1;
        end else if (cmd_i.resume) begin
            suspended <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scan_st <= S_IDLE;
            lead_cnt <= '0;
            scan_start_o <= 1'b0;
        end else begin
            scan_start_o <= 1'b0;
            case (scan_st)
                S_IDLE: begin
                    if (cmd_i.scan_request && pause_applies) begin
                        scan_st <= S_LEAD;
                        lead_cnt <= '0;
                    end else if (cmd_i.scan_request) begin
                        scan_start_o <= 1'b1;
                    end
                end
                // requests arriving during lead or scan are dropped
                S_LEAD: begin
                    lead_cnt <= lead_cnt + 32'd1;
                    if (lead_done) begin
                        scan_st <= S_SCAN;
                        scan_start_o <= 1'b1;
                    end
                end
                S_SCAN: begin
                    if (cmd_i.scan_done) begin
                        scan_st <= S_IDLE;
                    end
                end
                default: scan_st <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            balance_drive_output_o <= DRIVE_RESET;
            ext_source_on_o <= DRIVE_RESET;
            int_switch_on_o <= DRIVE_RESET;
            internal_balance_select_o <= INTERNAL_SEL_RESET;
            adc_result_o <= '0;
            suspended_o <= 1'b0;
        end else begin
            // registered so the pins never glitch on mode or command edges
            balance_drive_output_o <= next_drive;
            ext_source_on_o <= ext_next;
            int_switch_on_o <= int_next;
            internal_balance_select_o <= internal_sel;
            adc_result_o <= adc_over ? ADC_FULL_SCALE : adc_raw_i[ADC_W-1:0];
            suspended_o <= suspended;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence lead_seq;
        scan_st == S_LEAD;
    endsequence

    // last lead cycle: the counter has covered the whole pre-scan gap
    sequence lead_end_seq;
        scan_st == S_LEAD && lead_done;
    endsequence

    sequence resume_seq;
        suspended && cmd_i.resume && !cmd_i.suspend;
    endsequence

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    ext_mode_off_a: assert property (!internal_sel |=> int_switch_on_o == '0)
        else $error("internal switch driven in external mode");
    int_mode_off_a: assert property (internal_sel |=> ext_source_on_o == '0)
        else $error("gate source driven in internal mode");
    source_follow_a: assert property (!internal_sel |=> ext_source_on_o == $past(next_drive))
        else $error("gate source does not follow command");
    sat_full_a: assert property (adc_over |=> adc_result_o == ADC_FULL_SCALE)
        else $error("over-range not saturated");
    suspend_off_a: assert property (cmd_i.suspend |=> ##1 balance_drive_output_o == '0)
        else $error("drive on after suspend");
    lead_off_a: assert property (lead_seq |=> balance_drive_output_o == '0)
        else $error("drive on during pre-scan lead");
    scan_after_lead_a: assert property (lead_end_seq |=> scan_start_o && scan_st == S_SCAN)
        else $error("scan not started after lead");
    manual_follow_a: assert property (mode_i == MODE_MANUAL && balance_run_i && !suspended
        && !scan_paused |=> balance_drive_output_o == $past(manual_bits_i))
        else $error("manual output mismatch");
    restore_a: assert property (scan_st == S_SCAN && cmd_i.scan_done && !suspended && balance_run_i
        |=> ##1 balance_drive_output_o == $past(commanded))
        else $error("drive not restored after scan");

    lead_bound_a: assert property (lead_seq |-> lead_cnt <= 32'(PAUSE_CYC))
        else $error("lead counter past its limit");
    pause_enter_a: assert property (scan_st == S_IDLE && cmd_i.scan_request && pause_applies |=> lead_seq)
        else $error("paused request did not start lead");
    // the start pulse after a lead must see the counter one past the full gap
    lead_span_a: assert property (scan_start_o && scan_st == S_SCAN |-> lead_cnt == 32'(PAUSE_CYC + 1))
        else $error("lead shorter than the pre-scan gap");
    direct_start_a: assert property (scan_st == S_IDLE && cmd_i.scan_request
        && !pause_applies |=> scan_start_o)
        else $error("unpaused request gave no start");
    resume_restore_a: assert property (resume_seq ##1 (balance_run_i && !scan_paused)
        |=> balance_drive_output_o == $past(commanded))
        else $error("drive not restored after resume");
    run_off_a: assert property (!balance_run_i
        |=> balance_drive_output_o == '0 && ext_source_on_o == '0 && int_switch_on_o == '0)
        else $error("drive on while balancing stopped");
    select_follow_a: assert property (setup_we_i
        |=> ##1 internal_balance_select_o == $past(setup_data_i[INTERNAL_SEL_BIT], 2))
        else $error("select bit not taken from setup word");
    suspend_flag_a: assert property (cmd_i.suspend |=> ##1 suspended_o)
        else $error("suspend flag not raised");
    // first edge after release still shows the reset values
    reset_off_a: assert property ($rose(rst_n_i)
        |-> !internal_balance_select_o && balance_drive_output_o == '0)
        else $error("outputs not at reset values");
    adc_pass_a: assert property (!adc_over |=> adc_result_o == $past(adc_raw_i[ADC_W-1:0]))
        else $error("in-range code altered");
    int_follow_a: assert property (internal_sel |=> int_switch_on_o == $past(next_drive))
        else $error("internal switch does not follow command");
    seq_follow_a: assert property (mode_i != MODE_MANUAL && balance_run_i && !suspended && !scan_paused
        |=> balance_drive_output_o == $past(seq_bits_i))
        else $error("sequencer pattern not driven");
endmodule
`default_nettype wire

/* File: sim/cell_balance_host.sv */
// Purpose: host model sending one-cycle balance commands
// Assumes: commands launched on the falling edge
// Notes: k selects suspend 3, resume 2, request 1, done 0
`timescale 1ns/100ps
`default_nettype none
module cell_balance_host (
    input wire logic sys_clk_i,
    output var cell_balance_pkg::balance_cmd_s cmd_o
);
    import cell_balance_pkg::*;
    initial cmd_o = '0;
    // test_suspend suspends before a request and resumes after done; test_scan sends its requests unsuspended
    task automatic pulse(input int k);
        @(negedge sys_clk_i);
        cmd_o = balance_cmd_s'(4'h1 << k);
        @(negedge sys_clk_i);
        cmd_o = '0;
    endtask
endmodule
`default_nettype wire

/* File: sim/cell_balance_drive_control_tb.sv */
// Purpose: self-checking bench for the balance drive control
// Assumes: lead time shortened to 8 cycles
// Notes: inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
module cell_balance_drive_control_tb;
    import cell_balance_pkg::*;
    localparam int P = 8;
    logic sys_clk_i, rst_n_i, setup_we_i, balance_run_i, scan_pause_enable_i, scan_continuous_i;
    logic internal_balance_select_o, scan_start_o, suspended_o;
    logic [SETUP_W-1:0] setup_data_i;
    logic [NUM_CELLS-1:0] manual_bits_i, seq_bits_i, balance_drive_output_o, ext_source_on_o, int_switch_on_o;
    logic [ADC_W:0] adc_raw_i;
    logic [ADC_W-1:0] adc_result_o;
    balance_mode_e mode_i;
    balance_cmd_s cmd_i;
    int num_errors = 0;
    int comparisons = 0;
    cell_balance_host host (.sys_clk_i(sys_clk_i), .cmd_o(cmd_i));
    cell_balance_drive_control #(.PAUSE_CYC(P)) dut (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .setup_we_i(setup_we_i),
        .setup_data_i(setup_data_i),
        .manual_bits_i(manual_bits_i),
        .seq_bits_i(seq_bits_i),
        .mode_i(mode_i),
        .balance_run_i(balance_run_i),
        .scan_pause_enable_i(scan_pause_enable_i),
        .scan_continuous_i(scan_continuous_i),
        .cmd_i(cmd_i),
        .adc_raw_i(adc_raw_i),
        .internal_balance_select_o(internal_balance_select_o),
        .balance_drive_output_o(balance_drive_output_o),
        .ext_source_on_o(ext_source_on_o),
        .int_switch_on_o(int_switch_on_o),
        .adc_result_o(adc_result_o),
        .scan_start_o(scan_start_o),
        .suspended_o(suspended_o)
    );
    initial begin
        sys_clk_i = 0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic test_manual();
        manual_bits_i = 14'h2a5a;
        ticks(2);
        check(balance_drive_output_o, 14'h2a5a, "manual drive");
        check(ext_source_on_o, 14'h2a5a, "gate sources");
        check(int_switch_on_o, 0, "internal idle");
        setup_data_i = 16'h0100;
        setup_we_i = 1;
        ticks(1);
        setup_we_i = 0;
        ticks(2);
        check(internal_balance_select_o, 1, "select set");
        check(int_switch_on_o, 14'h2a5a, "internal drive");
        check(ext_source_on_o, 0, "gate sources off");
        setup_data_i = 16'h0000;
        setup_we_i = 1;
        ticks(1);
        setup_we_i = 0;
        ticks(2);
        check(ext_source_on_o, 14'h2a5a, "back to external");
        check(int_switch_on_o, 0, "internal off again");
        $display("manual test done");
    endtask
    task automatic test_suspend();
        host.pulse(3);
        ticks(1);
        check(balance_drive_output_o, 0, "suspended drive");
        check(suspended_o, 1, "suspend flag");
        host.pulse(1);
        check(scan_start_o, 1, "unpaused start");
        host.pulse(0);
        host.pulse(2);
        ticks(1);
        check(balance_drive_output_o, 14'h2a5a, "restored");
        check(suspended_o, 0, "suspend flag cleared");
        $display("suspend test done");
    endtask
    task automatic test_scan(input balance_mode_e m, input logic [NUM_CELLS-1:0] pat);
        int i;
        mode_i = m;
        seq_bits_i = pat;
        scan_pause_enable_i = 1;
        scan_continuous_i = 1;
        ticks(2);
        check(balance_drive_output_o, pat, "sequencer drive");
        host.pulse(1);
        ticks(1);
        check(balance_drive_output_o, 0, "paused drive");
        // counts edges after the request edge; a short lead would spoil readings
        for (i = 1; scan_start_o !== 1'b1 && i < 40; i++) ticks(1);
        check(i, P + 1, "lead time");
        check(balance_drive_output_o, 0, "off at start");
        if (i >= 40) complete_run();
        host.pulse(0);
        ticks(1);
        check(balance_drive_output_o, pat, "scan resume");
        $display("scan test done");
    endtask
    task automatic test_run_off();
        balance_run_i = 0;
        ticks(1);
        check(balance_drive_output_o, 0, "run off drive");
        check(ext_source_on_o, 0, "run off sources");
        balance_run_i = 1;
        ticks(1);
        check(ext_source_on_o, 14'h3001, "run on sources");
        $display("run test done");
    endtask
    task automatic test_adc();
        adc_raw_i = 15'h3fff;
        ticks(1);
        check(adc_result_o, 14'h3fff, "top code");
        adc_raw_i = 15'h4001;
        ticks(1);
        check(adc_result_o, ADC_FULL_SCALE, "saturate");
        $display("adc test done");
    endtask
    initial begin
        {rst_n_i, setup_we_i, setup_data_i, scan_pause_enable_i, scan_continuous_i, adc_raw_i} = '0;
        {manual_bits_i, seq_bits_i, balance_run_i, mode_i} = {14'h1555, 14'h0c03, 1'b1, MODE_MANUAL};
        ticks(5);
        check(balance_drive_output_o, 0, "drive in reset");
        check(internal_balance_select_o, INTERNAL_SEL_RESET, "reset select");
        rst_n_i = 1;
        ticks(1);
        test_manual();
        test_suspend();
        test_scan(MODE_TIMED, 14'h0c03);
        test_scan(MODE_AUTO, 14'h3001);
        test_run_off();
        test_adc();
        complete_run();
    end
endmodule
`default_nettype wire
